// ---- rtl/ioc_defines.vh ----
// constants shared by the channel logic: register map, field layout,
// status byte bits, condition codes and the burst time-out.
// assumes a 25 MHz system clock.
`ifndef IOC_DEFINES_VH
`define IOC_DEFINES_VH
// number of subchannels and the width of their index
`define IOC_NSUB 4
`define IOC_SW 2
// apb register byte offsets
`define IOC_OFF_MODE 8'h00
`define IOC_OFF_START 8'h04
`define IOC_OFF_STAT 8'h08
`define IOC_OFF_CSWA 8'h0c
`define IOC_OFF_CSWC 8'h10
`define IOC_OFF_ACK 8'h14
// fixed storage location of the command_list_pointer_word
`define IOC_PTR_LOC 24'h000048
// command_list_pointer_word: key [31:28], descriptor address [23:0]
`define IOC_KEY_HI 31
`define IOC_KEY_LO 28
// descriptor word 0: command [31:24], data address [23:0]
// descriptor word 1: data chain [31], command chain [30], count [15:0]
`define IOC_CMD_HI 31
`define IOC_CMD_LO 24
`define IOC_DC_BIT 31
`define IOC_CC_BIT 30
`define IOC_CMD_IN 0
`define IOC_DESC_STEP 24'h000008
`define IOC_WORD_STEP 24'h000004
// status byte bits from the device
`define IOC_ST_BUSY 4
`define IOC_ST_CE 3
`define IOC_ST_DE 2
`define IOC_ST_CUE 1
`define IOC_ST_UC 0
// condition codes of the start request
`define IOC_CC_OK 2'h0
`define IOC_CC_PEND 2'h1
`define IOC_CC_BUSY 2'h2
// burst time-out
`define IOC_BURST_NS 100000
`define IOC_CLK_NS 40
`define IOC_BURST_CYC ((`IOC_BURST_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`define IOC_TMR_W 12
`endif

// ---- rtl/ioc_sync.v ----
// two flip-flop synchroniser for a group of pin inputs.
// assumes data pins are stable before their qualifying tag rises.
`timescale 1ns/1ps
`default_nettype none
module ioc_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  // first stage feeds only the second
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule
`default_nettype wire

// ---- rtl/ioc_burst_tmr.v ----
// connection timer: flags burst mode once a device stays
// connected past the burst time-out.
// assumes conn_i is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_defines.vh"
module ioc_burst_tmr (
  input wire clk_i,
  input wire sys_rst_i,
  input wire conn_i,
  output wire burst_o
);
  localparam integer LIM = `IOC_BURST_CYC;
  wire [`IOC_TMR_W-1:0] lim_last = LIM[`IOC_TMR_W-1:0] - 1'b1;
  reg [`IOC_TMR_W-1:0] cnt_r;
  reg burst_r;
  // count connected cycles, burst holds until disconnect
  always @(posedge clk_i)
  begin
    if (sys_rst_i || !conn_i)
    begin
      cnt_r <= {`IOC_TMR_W{1'b0}};
      burst_r <= 1'b0;
    end
    else if (cnt_r == lim_last)
      burst_r <= 1'b1;
    else
      cnt_r <= cnt_r + 1'b1;
  end
  assign burst_o = burst_r;
endmodule
`default_nettype wire

// ---- rtl/ioc_channel.v ----
// channel controller with four subchannels, apb register port,
// storage port and a tag-handshake device interface.
// assumes a single-cycle-ack storage slave on clk_i and devices
// that hold bus_in stable while their in-tag is high.
// Function
// - selector mode: one subchannel, forced burst, one transfer at a time
// - selector burst spans whole block or whole command chain
// - idle selector channel polls its devices for status
// - multiplexor: device picks multiplex or burst at any time
// - one concurrent operation per subchannel, each independent
// - idle multiplexor watches devices for data and interrupt requests
// - during burst only the bursting subchannel answers devices
// - start fetches pointer word, takes key, fetches first descriptor
// - broadcast device address, control unit echoes it back
// - send command code, device answers with status byte
// - start completes on initial status, gives condition code
// - data operation: subchannel answers device service requests
// - data chaining fetches next descriptor silently on exhaustion
// - transfer-done reports last descriptor address and residual count
// - command chaining on unit-done fetches and selects anew silently
// - unusual condition suppresses chaining and ends the program
// - one interruption at a time, conditions held until accepted
// - subchannel busy until transfer-done of last operation accepted
// - unit-done busies device, controller-free blocks control unit
// - connection past 100 us is burst mode, set by time-out
// - burst mode answers busy to new starts
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_defines.vh"
module ioc_channel (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] paddr_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  output wire mem_req_o,
  output wire mem_we_o,
  output wire [23:0] mem_addr_o,
  output wire [3:0] mem_be_o,
  output wire [31:0] mem_wdata_o,
  output wire [3:0] mem_key_o,
  input wire [31:0] mem_rdata_i,
  input wire mem_ack_i,
  output wire [7:0] bus_out_o,
  output wire addr_out_o,
  output wire cmd_out_o,
  output wire srv_out_o,
  input wire [15:0] bus_in_i,
  input wire op_in_i,
  input wire sta_in_i,
  input wire srv_in_i
);
  // ****************************************
  // states
  // ****************************************
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_PTR = 4'h1;
  localparam [3:0] S_D0 = 4'h2;
  localparam [3:0] S_D1 = 4'h3;
  localparam [3:0] S_SEL = 4'h4;
  localparam [3:0] S_CMD = 4'h5;
  localparam [3:0] S_CMDW = 4'h6;
  localparam [3:0] S_ENDS = 4'h7;
  localparam [3:0] S_MEMS = 4'h8;
  localparam [3:0] S_MEM = 4'h9;
  localparam [3:0] S_SACK = 4'ha;
  localparam [3:0] S_STW = 4'hb;
  localparam N = `IOC_NSUB;
  // ****************************************
  // storage
  // ****************************************
  reg [3:0] state_r;
  reg [23:0] sc_adr_r [0:N-1];
  reg [15:0] sc_cnt_r [0:N-1];
  reg [23:0] sc_ccw_r [0:N-1];
  reg [7:0] sc_cmd_r [0:N-1];
  reg [1:0] sc_fl_r [0:N-1];
  reg [7:0] sc_st_r [0:N-1];
  reg [3:0] sc_key_r [0:N-1];
  reg [7:0] sc_dev_r [0:N-1];
  reg [N-1:0] sc_busy_r;
  reg [N-1:0] sc_pend_r;
  reg [N-1:0] sc_uc_r;
  reg [`IOC_SW-1:0] sub_r;
  reg [7:0] st_r;
  reg [7:0] dat_r;
  reg from_start_r;
  reg ret_srv_r;
  reg [1:0] cc_r;
  reg start_pend_r;
  reg [7:0] start_dev_r;
  reg mode_sel_r;
  reg cue_blk_r;
  reg [3:0] cue_cu_r;
  reg [23:0] csw_a_r;
  reg [23:0] csw_c_r;
  reg [`IOC_SW-1:0] ack_sub_r;
  reg ack_v_r;
  reg [7:0] bus_out_r;
  reg addr_out_r;
  reg cmd_out_r;
  reg srv_out_r;
  reg mem_req_r;
  reg mem_we_r;
  reg [23:0] mem_addr_r;
  reg [3:0] mem_be_r;
  reg [31:0] mem_wdata_r;
  reg [31:0] prdata_r;
  integer i;
  // ****************************************
  // pin synchronisers and burst timer
  // ****************************************
  wire [18:0] pins_s;
  ioc_sync #(.W(19)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({op_in_i, sta_in_i, srv_in_i, bus_in_i}),
    .q_o(pins_s)
  );
  wire op_s = pins_s[18];
  wire sta_s = pins_s[17];
  wire srv_s = pins_s[16];
  wire [15:0] in_s = pins_s[15:0];
  wire burst_t;
  ioc_burst_tmr u_tmr (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .conn_i(op_s),
    .burst_o(burst_t)
  );
  // selector mode holds burst for the whole chain
  wire burst_w = mode_sel_r ? (sc_busy_r[0] & ~sc_pend_r[0]) : burst_t;
  // device address to subchannel, selector maps all to one
  wire [`IOC_SW-1:0] in_sub = mode_sel_r ? {`IOC_SW{1'b0}} : in_s[9:8];
  wire [`IOC_SW-1:0] st_sub = mode_sel_r ? {`IOC_SW{1'b0}} : start_dev_r[1:0];
  // other subchannels stay dormant during a burst
  wire dormant = burst_t && (in_sub != sub_r);
  wire cu_blk = cue_blk_r && (cue_cu_r == start_dev_r[7:4]);
  wire [31:0] rd_sh = mem_rdata_i >> {mem_addr_r[1:0], 3'b000};
  // ****************************************
  // interruption priority, lowest index first
  // ****************************************
  wire [N-1:0] lower;
  wire [N-1:0] gnt;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_prio
      if (g == 0)
      begin : g_first
        assign lower[g] = 1'b0;
      end
      else
      begin : g_rest
        assign lower[g] = |sc_pend_r[g-1:0];
      end
      assign gnt[g] = sc_pend_r[g] & ~lower[g];
    end
  endgenerate
  wire [`IOC_SW-1:0] gsub = {gnt[3] | gnt[2], gnt[3] | gnt[1]};
  // ****************************************
  // apb decode
  // ****************************************
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire hit = (paddr_i == `IOC_OFF_MODE) || (paddr_i == `IOC_OFF_START) ||
    (paddr_i == `IOC_OFF_STAT) || (paddr_i == `IOC_OFF_CSWA) ||
    (paddr_i == `IOC_OFF_CSWC) || (paddr_i == `IOC_OFF_ACK);
  assign pready_o = acc;
  assign pslverr_o = acc & ~hit;
  assign prdata_o = prdata_r;
  // read data captured in the setup cycle
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      prdata_r <= 32'h0000_0000;
    else if (psel_i && !penable_i)
    begin
      case (paddr_i)
        `IOC_OFF_MODE: prdata_r <= {31'h0, mode_sel_r};
        `IOC_OFF_START: prdata_r <= {29'h0, start_pend_r, cc_r};
        `IOC_OFF_STAT: prdata_r <= {22'h0, cue_blk_r, burst_w, sc_pend_r, sc_busy_r};
        `IOC_OFF_CSWA: prdata_r <= {8'h00, csw_a_r};
        `IOC_OFF_CSWC: prdata_r <= {8'h00, csw_c_r};
        `IOC_OFF_ACK: prdata_r <= {29'h0, ack_v_r, ack_sub_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end
  // ****************************************
  // channel sequencer
  // ****************************************
  // register writes first, sequencer sets after so a set wins
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= S_IDLE;
      for (i = 0; i < N; i = i + 1)
      begin
        sc_adr_r[i] <= 24'h000000;
        sc_cnt_r[i] <= 16'h0000;
        sc_ccw_r[i] <= 24'h000000;
        sc_cmd_r[i] <= 8'h00;
        sc_fl_r[i] <= 2'h0;
        sc_st_r[i] <= 8'h00;
        sc_key_r[i] <= 4'h0;
        sc_dev_r[i] <= 8'h00;
      end
      sc_busy_r <= {N{1'b0}};
      sc_pend_r <= {N{1'b0}};
      sc_uc_r <= {N{1'b0}};
      sub_r <= {`IOC_SW{1'b0}};
      st_r <= 8'h00;
      dat_r <= 8'h00;
      from_start_r <= 1'b0;
      ret_srv_r <= 1'b0;
      cc_r <= `IOC_CC_OK;
      start_pend_r <= 1'b0;
      start_dev_r <= 8'h00;
      mode_sel_r <= 1'b0;
      cue_blk_r <= 1'b0;
      cue_cu_r <= 4'h0;
      csw_a_r <= 24'h000000;
      csw_c_r <= 24'h000000;
      ack_sub_r <= {`IOC_SW{1'b0}};
      ack_v_r <= 1'b0;
      bus_out_r <= 8'h00;
      addr_out_r <= 1'b0;
      cmd_out_r <= 1'b0;
      srv_out_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 24'h000000;
      mem_be_r <= 4'h0;
      mem_wdata_r <= 32'h0000_0000;
    end
    else
    begin
      // software side: mode, start request, interruption acceptance
      if (wr && paddr_i == `IOC_OFF_MODE)
        mode_sel_r <= pwdata_i[0];
      if (wr && paddr_i == `IOC_OFF_START && !start_pend_r)
      begin
        start_pend_r <= 1'b1;
        start_dev_r <= pwdata_i[7:0];
      end
      if (wr && paddr_i == `IOC_OFF_ACK)
      begin
        ack_v_r <= |sc_pend_r;
        ack_sub_r <= gsub;
        if (|sc_pend_r)
        begin
          csw_a_r <= sc_ccw_r[gsub];
          csw_c_r <= {sc_st_r[gsub], sc_cnt_r[gsub]};
          sc_pend_r[gsub] <= 1'b0;
          if (sc_st_r[gsub][`IOC_ST_CE])
          begin
            sc_busy_r[gsub] <= 1'b0;
            sc_uc_r[gsub] <= 1'b0;
          end
          if (sc_st_r[gsub][`IOC_ST_CUE])
            cue_blk_r <= 1'b0;
        end
      end
      case (state_r)
        // monitor devices, serve data before new starts
        S_IDLE:
        begin
          if (srv_s && sc_busy_r[in_sub] && !dormant)
          begin
            sub_r <= in_sub;
            dat_r <= in_s[7:0];
            if (sc_cnt_r[in_sub] == 16'h0000 && sc_fl_r[in_sub][1])
            begin
              ret_srv_r <= 1'b1;
              from_start_r <= 1'b0;
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b0;
              mem_be_r <= 4'hf;
              mem_addr_r <= sc_ccw_r[in_sub] + `IOC_DESC_STEP;
              sc_ccw_r[in_sub] <= sc_ccw_r[in_sub] + `IOC_DESC_STEP;
              state_r <= S_D0;
            end
            else
              state_r <= S_MEMS;
          end
          else if (sta_s && !dormant)
          begin
            sub_r <= in_sub;
            st_r <= in_s[7:0];
            from_start_r <= 1'b0;
            srv_out_r <= 1'b1;
            state_r <= S_STW;
          end
          else if (start_pend_r)
          begin
            sub_r <= st_sub;
            if (burst_w || sc_busy_r[st_sub] || cu_blk)
            begin
              cc_r <= `IOC_CC_BUSY;
              start_pend_r <= 1'b0;
            end
            else
            begin
              from_start_r <= 1'b1;
              ret_srv_r <= 1'b0;
              sc_dev_r[st_sub] <= start_dev_r;
              sc_uc_r[st_sub] <= 1'b0;
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b0;
              mem_be_r <= 4'hf;
              mem_addr_r <= `IOC_PTR_LOC;
              state_r <= S_PTR;
            end
          end
        end
        // pointer word: key and first descriptor address
        S_PTR:
        begin
          if (mem_ack_i)
          begin
            sc_key_r[sub_r] <= mem_rdata_i[`IOC_KEY_HI:`IOC_KEY_LO];
            sc_ccw_r[sub_r] <= mem_rdata_i[23:0];
            mem_addr_r <= mem_rdata_i[23:0];
            state_r <= S_D0;
          end
        end
        S_D0:
        begin
          if (mem_ack_i)
          begin
            sc_cmd_r[sub_r] <= mem_rdata_i[`IOC_CMD_HI:`IOC_CMD_LO];
            sc_adr_r[sub_r] <= mem_rdata_i[23:0];
            mem_addr_r <= sc_ccw_r[sub_r] + `IOC_WORD_STEP;
            state_r <= S_D1;
          end
        end
        S_D1:
        begin
          if (mem_ack_i)
          begin
            sc_fl_r[sub_r] <= {mem_rdata_i[`IOC_DC_BIT], mem_rdata_i[`IOC_CC_BIT]};
            sc_cnt_r[sub_r] <= mem_rdata_i[15:0];
            mem_req_r <= 1'b0;
            if (ret_srv_r)
              state_r <= S_MEMS;
            else
            begin
              addr_out_r <= 1'b1;
              bus_out_r <= sc_dev_r[sub_r];
              state_r <= S_SEL;
            end
          end
        end
        // selection: wait for the address echo
        S_SEL:
        begin
          if (op_s && in_s[15:8] == sc_dev_r[sub_r])
          begin
            addr_out_r <= 1'b0;
            cmd_out_r <= 1'b1;
            bus_out_r <= sc_cmd_r[sub_r];
            state_r <= S_CMD;
          end
        end
        S_CMD:
        begin
          if (sta_s)
          begin
            st_r <= in_s[7:0];
            cmd_out_r <= 1'b0;
            state_r <= S_CMDW;
          end
        end
        S_CMDW:
        begin
          if (!sta_s)
            state_r <= S_ENDS;
        end
        // status evaluation: condition code, chaining, pending
        S_ENDS:
        begin
          state_r <= S_IDLE;
          if (from_start_r)
          begin
            start_pend_r <= 1'b0;
            if (st_r[`IOC_ST_BUSY])
              cc_r <= `IOC_CC_BUSY;
            else if (st_r[`IOC_ST_CE] || st_r[`IOC_ST_DE])
              cc_r <= `IOC_CC_PEND;
            else
              cc_r <= `IOC_CC_OK;
          end
          if (!(from_start_r && st_r[`IOC_ST_BUSY]))
          begin
            if (from_start_r)
              sc_busy_r[sub_r] <= 1'b1;
            if (st_r[`IOC_ST_CUE])
            begin
              cue_blk_r <= 1'b1;
              cue_cu_r <= sc_dev_r[sub_r][7:4];
            end
            if (st_r[`IOC_ST_DE] && sc_fl_r[sub_r][0] && !st_r[`IOC_ST_UC] && !sc_uc_r[sub_r])
            begin
              from_start_r <= 1'b0;
              ret_srv_r <= 1'b0;
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b0;
              mem_be_r <= 4'hf;
              mem_addr_r <= sc_ccw_r[sub_r] + `IOC_DESC_STEP;
              sc_ccw_r[sub_r] <= sc_ccw_r[sub_r] + `IOC_DESC_STEP;
              state_r <= S_D0;
            end
            else if (st_r[`IOC_ST_CE] || st_r[`IOC_ST_DE] || st_r[`IOC_ST_UC] ||
              st_r[`IOC_ST_CUE] || (!from_start_r && !sc_busy_r[sub_r]))
            begin
              sc_pend_r[sub_r] <= 1'b1;
              sc_st_r[sub_r] <= st_r | {7'h00, sc_uc_r[sub_r]};
            end
          end
        end
        // data byte: storage access set up from the subchannel
        S_MEMS:
        begin
          if (sc_cnt_r[sub_r] == 16'h0000)
          begin
            sc_uc_r[sub_r] <= 1'b1;
            srv_out_r <= 1'b1;
            state_r <= S_SACK;
          end
          else
          begin
            mem_req_r <= 1'b1;
            mem_we_r <= sc_cmd_r[sub_r][`IOC_CMD_IN];
            mem_addr_r <= sc_adr_r[sub_r];
            mem_be_r <= 4'h1 << sc_adr_r[sub_r][1:0];
            mem_wdata_r <= {4{dat_r}};
            state_r <= S_MEM;
          end
        end
        S_MEM:
        begin
          if (mem_ack_i)
          begin
            mem_req_r <= 1'b0;
            if (!mem_we_r)
              bus_out_r <= rd_sh[7:0];
            sc_adr_r[sub_r] <= sc_adr_r[sub_r] + 24'h000001;
            sc_cnt_r[sub_r] <= sc_cnt_r[sub_r] - 16'h0001;
            srv_out_r <= 1'b1;
            state_r <= S_SACK;
          end
        end
        S_SACK:
        begin
          if (!srv_s)
          begin
            srv_out_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        S_STW:
        begin
          if (!sta_s)
          begin
            srv_out_r <= 1'b0;
            state_r <= S_ENDS;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign mem_req_o = mem_req_r;
  assign mem_we_o = mem_we_r;
  assign mem_addr_o = mem_addr_r;
  assign mem_be_o = mem_be_r;
  assign mem_wdata_o = mem_wdata_r;
  assign mem_key_o = sc_key_r[sub_r];
  assign bus_out_o = bus_out_r;
  assign addr_out_o = addr_out_r;
  assign cmd_out_o = cmd_out_r;
  assign srv_out_o = srv_out_r;
endmodule
`default_nettype wire

// ---- bench/ioc_channel_monitor.sv ----
// checker for the channel's apb, storage and tag pins.
// assumes it is bound to ioc_channel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ioc_channel_monitor (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] paddr_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire mem_req_o,
  input wire mem_ack_i,
  input wire [23:0] mem_addr_o,
  input wire [31:0] mem_rdata_i,
  input wire [7:0] bus_out_o,
  input wire addr_out_o,
  input wire cmd_out_o,
  input wire srv_out_o,
  input wire op_in_i,
  input wire sta_in_i,
  input wire srv_in_i
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // bus answer and unmapped error
  a_apb_answer: assert property (psel_i && penable_i |-> pready_o && (paddr_i <= 8'h14 || pslverr_o))
    else $error("apb answer wrong");
  // storage request held until answered
  a_req_held: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("storage request moved");
  // pointer word names the descriptor fetched next
  a_ptr_desc: assert property (mem_ack_i && mem_req_o && mem_addr_o == 24'h000048
    |=> {8'h00, mem_addr_o} == ($past(mem_rdata_i) & 32'h00ffffff)) else $error("descriptor address wrong");
  // device address steady during selection
  a_sel_steady: assert property (addr_out_o && $past(addr_out_o) |-> $stable(bus_out_o))
    else $error("address moved");
  // command only after the echo
  a_cmd_echo: assert property ($rose(cmd_out_o) |-> $past(op_in_i, 2) && !addr_out_o)
    else $error("command before echo");
  // command dropped only after status
  a_cmd_drop: assert property ($fell(cmd_out_o) |-> $past(sta_in_i, 2))
    else $error("command dropped early");
  // command tag never up together with the address or service tag
  a_one_tag: assert property (!(addr_out_o && cmd_out_o) && !(cmd_out_o && srv_out_o))
    else $error("two tags up");
  // answer only to a device request
  a_srv_cause: assert property ($rose(srv_out_o) |-> $past(srv_in_i, 2) || $past(sta_in_i, 2))
    else $error("answer without request");
  // outputs quiet after reset
  a_rst_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    sys_rst_i |=> !(mem_req_o || addr_out_o || cmd_out_o || srv_out_o)) else $error("busy in reset");
  // main scenarios
  c_start: cover property (psel_i && penable_i && paddr_i == 8'h04);
  c_cmd: cover property ($rose(cmd_out_o));
  c_srv: cover property ($rose(srv_out_o));
endmodule
bind ioc_channel ioc_channel_monitor mon_u (.clk_i, .sys_rst_i, .paddr_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .mem_req_o, .mem_ack_i, .mem_addr_o, .mem_rdata_i, .bus_out_o, .addr_out_o, .cmd_out_o,
  .srv_out_o, .op_in_i, .sta_in_i, .srv_in_i);
`default_nettype wire

// ---- bench/ioc_dev_model.sv ----
// far side model: storage slave and one control unit with devices.
// assumes it shares clk_i with ioc_channel.
`timescale 1ns/1ps
`default_nettype none
module ioc_dev_model (
  input wire logic clk_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic [31:0] mem_rdata_o,
  output logic mem_ack_o,
  input wire logic [7:0] bus_out_i,
  input wire logic addr_out_i,
  input wire logic cmd_out_i,
  input wire logic srv_out_i,
  output logic [15:0] bus_in_o,
  output logic op_in_o,
  output logic sta_in_o,
  output logic srv_in_o,
  input wire logic [7:0] stat_i,
  input wire logic req_i,
  input wire logic kind_i,
  input wire logic hold_i,
  output logic [7:0] wr_byte_o
);
  // ****
  // storage and device
  // ****
  logic [31:0] mem [0:31];
  logic [7:0] dev_r;
  logic sel_r;
  // quiet pins at time zero
  initial
    {mem_rdata_o, mem_ack_o, bus_in_o, op_in_o, sta_in_o, srv_in_o, sel_r, wr_byte_o} = '0;
  // storage answers a request one cycle later
  always @(posedge clk_i)
  begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_req_i && !mem_ack_o)
    begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem[mem_addr_i[6:2]];
      if (mem_we_i)
        wr_byte_o <= mem_wdata_i[7:0];
    end
  end
  // device side of the tag handshake
  always @(posedge clk_i)
  begin
    if (!op_in_o)
      bus_in_o <= ~bus_in_o;
    if (!hold_i && !sel_r && !srv_in_o && !sta_in_o)
      op_in_o <= 1'b0;
    if (addr_out_i && !op_in_o)
    begin
      op_in_o <= 1'b1;
      sel_r <= 1'b1;
      dev_r <= bus_out_i;
      bus_in_o <= {bus_out_i, 8'h00};
    end
    if (cmd_out_i && sel_r && !sta_in_o)
    begin
      sta_in_o <= 1'b1;
      bus_in_o[7:0] <= stat_i;
    end
    if (sel_r && sta_in_o && !cmd_out_i)
    begin
      sta_in_o <= 1'b0;
      sel_r <= 1'b0;
    end
    if (req_i && !op_in_o && !sel_r)
    begin
      op_in_o <= 1'b1;
      srv_in_o <= !kind_i;
      sta_in_o <= kind_i;
      bus_in_o <= {dev_r, stat_i};
    end
    if (!sel_r && srv_out_i && (srv_in_o || sta_in_o))
    begin
      srv_in_o <= 1'b0;
      sta_in_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench: apb tasks, far side model, test sequence.
// assumes design, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] paddr_i = 8'h00, stat = 8'h00;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic req = 1'b0, kind = 1'b0, hold = 1'b0;
  logic [31:0] q;
  logic err;
  int error_cnt = 0, n_checks = 0;
  wire [31:0] prdata_o, mem_wdata_o, mem_rdata_i;
  wire [23:0] mem_addr_o;
  wire [15:0] bus_in_i;
  wire [7:0] bus_out_o, wr_byte;
  wire pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ack_i;
  wire addr_out_o, cmd_out_o, srv_out_o, op_in_i, sta_in_i, srv_in_i;
  // ****
  // clock, design and far side
  // ****
  always #20 clk_i = ~clk_i;
  ioc_channel dut_u (.clk_i, .sys_rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_be_o(), .mem_wdata_o,
    .mem_key_o(), .mem_rdata_i, .mem_ack_i, .bus_out_o, .addr_out_o, .cmd_out_o, .srv_out_o,
    .bus_in_i, .op_in_i, .sta_in_i, .srv_in_i);
  ioc_dev_model dev_u (.clk_i(clk_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i),
    .bus_out_i(bus_out_o), .addr_out_i(addr_out_o), .cmd_out_i(cmd_out_o), .srv_out_i(srv_out_o),
    .bus_in_o(bus_in_i), .op_in_o(op_in_i), .sta_in_o(sta_in_i), .srv_in_o(srv_in_i), .stat_i(stat),
    .req_i(req), .kind_i(kind), .hold_i(hold), .wr_byte_o(wr_byte));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask
  // start a device and wait until the start result settles
  task automatic start(input logic [7:0] dev, input logic [31:0] exp);
    int n;
    apb(1'b1, 8'h04, {24'h0, dev});
    for (n = 0; n < 100 && (n == 0 || q[2] !== 1'b0); n++)
      apb(1'b0, 8'h04, 32'h0);
    chk(q, exp);
  endtask
  // device asks for service or presents status
  task automatic talk(input logic k, input logic [7:0] v);
    kind <= k;
    stat <= v;
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    while (srv_out_o !== 1'b1)
      @(posedge clk_i);
    while (srv_out_o !== 1'b0)
      @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    dev_u.mem[18] = 32'h30000010;
    dev_u.mem[4] = 32'h02000060;
    dev_u.mem[5] = 32'h00000005;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 32'hffffffff, 32'h0);
    rd(8'h08, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test 1 done");
    stat <= 8'h0c;
    start(8'h01, 32'h1);
    rd(8'h08, 32'h000000f0, 32'h20);
    apb(1'b1, 8'h14, 32'h0);
    rd(8'h14, 32'h7, 32'h5);
    rd(8'h10, 32'h00ffffff, 32'h000c0005);
    rd(8'h0c, 32'h00ffffff, 32'h10);
    rd(8'h08, 32'hff, 32'h0);
    $display("test 2 done");
    dev_u.mem[4] = 32'h01000060;
    dev_u.mem[5] = 32'h00000001;
    stat <= 8'h00;
    start(8'h02, 32'h0);
    rd(8'h08, 32'hff, 32'h4);
    start(8'h02, 32'h2);
    talk(1'b0, 8'ha5);
    chk({24'h0, wr_byte}, 32'ha5);
    talk(1'b1, 8'h0c);
    apb(1'b1, 8'h14, 32'h0);
    rd(8'h10, 32'h00ffffff, 32'h000c0000);
    rd(8'h08, 32'hff, 32'h0);
    $display("test 3 done");
    apb(1'b1, 8'h00, 32'h1);
    rd(8'h00, 32'h1, 32'h1);
    stat <= 8'h00;
    start(8'h05, 32'h0);
    rd(8'h08, 32'h1ff, 32'h101);
    start(8'h06, 32'h2);
    talk(1'b1, 8'h0e);
    rd(8'h08, 32'h3ff, 32'h211);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h08, 32'h3ff, 32'h0);
    $display("test 4 done");
    stat <= 8'h00;
    hold <= 1'b1;
    start(8'h03, 32'h0);
    repeat (2000) @(posedge clk_i);
    rd(8'h08, 32'h100, 32'h0);
    repeat (600) @(posedge clk_i);
    rd(8'h08, 32'h100, 32'h100);
    start(8'h01, 32'h2);
    $display("test 5 done");
    hold <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h08, 32'hffffffff, 32'h0);
    $display("test 6 done");
    print_verdict();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
